// ===== src/wdtr_pkg.sv
// Summary of operation
// [RULE1] The watchdog counter advances on a 1 MHz tick divided down from the 6 MHz oscillator rate; the code divides the 250 MHz hclk by 250.
// [RULE2] A kick instruction clears the watchdog counter and starts a new period.
// [RULE3] When enabled and the selected period elapses without a kick, a full device reset is issued.
// [RULE4] A write of zero to the enable bit is ignored unless the turn-off unlock bit is set at that time.
// [RULE5] The turn-off unlock bit clears itself once four clock cycles have elapsed after it was set.
// [RULE6] The watchdog runs while the enable bit is one and stops while it is zero.
// [RULE7] Software disables by writing unlock and enable as ones together, then enable zero within four cycles.
// [RULE8] The timeout select sets a period of 16K ticks at code zero, doubling per step up to 2048K ticks.
// [RULE9] Control bits 7 to 5 read as zero and cannot be written.
// [RULE10] Software should kick before enabling so the first period starts from zero.
// [RULE11] Software should disable or kick before changing the timeout select.
// [RULE12] The four-cycle window is counted in CPU clock cycles from the write that set the unlock bit.
package wdtr_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0]  CTRL_INDEX  = 8'h21;
	localparam logic [31:0] CTRL_ADDR   = {22'h0, CTRL_INDEX, 2'h0};
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam int          UNLOCK_BIT  = 4;
	localparam int          ENABLE_BIT  = 3;
	localparam int          SEL_MSB     = 2;
	localparam int          SEL_WIDTH   = 3;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 250;
	localparam int TICK_MHZ       = 1;
	localparam int TICK_DIV       = CLK_MHZ / TICK_MHZ;
	localparam int UNLOCK_CYCLES  = 4;
	localparam int BASE_TICKS     = 16384;
	localparam int CNT_WIDTH      = 22;
	localparam int RESET_PULSE    = 4;
endpackage : wdtr_pkg

// ===== src/wdtr_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// Tick and kick signals between the control and the counter
interface wdtr_tick_if;
	logic tick;
	logic kick;
	logic run;
	logic [2:0] sel;
	logic expired;
	modport ctrl (output tick, output kick, output run, output sel,
		input expired);
	modport cnt  (input tick, input kick, input run, input sel,
		output expired);
endinterface : wdtr_tick_if
`default_nettype wire

// ===== src/wdtr_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wdtr_counter #(
	parameter int BASE = wdtr_pkg::BASE_TICKS
) (
	// Clock and reset
	input  wire logic   hclk,
	input  wire logic   hresetn,
	// Control side
	wdtr_tick_if.cnt    tk
);
	localparam int W = wdtr_pkg::CNT_WIDTH;
	logic [W-1:0] cnt_q;
	logic [W-1:0] limit;
	logic         hit;
	logic         expired_q;

	// ------------------------------------------------------------
	// Period decode and terminal count
	// ------------------------------------------------------------
	// Limit doubles per select step; last count value of BASE<<sel ticks
	assign limit = (W'(BASE) << tk.sel) - W'(1); // [RULE8]
	assign hit   = tk.run && tk.tick && (cnt_q >= limit);
	assign tk.expired = expired_q;

	// Counter: kick wins over counting so a late kick still saves it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q     <= '0;
			expired_q <= 1'b0;
		end else begin
			expired_q <= hit && !tk.kick; // [RULE3]
			if (tk.kick || hit) begin
				cnt_q <= '0; // [RULE2]
			end else if (tk.run && tk.tick) begin
				cnt_q <= cnt_q + W'(1); // [RULE6]
			end
		end
	end
endmodule : wdtr_counter
`default_nettype wire

// ===== src/wdtr_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdtr_top #(
	parameter int BASE = wdtr_pkg::BASE_TICKS
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	// Core side
	input  wire logic        kick_instruction,
	output var  logic        device_reset_req
);
	// ------------------------------------------------------------
	// Local state
	// ------------------------------------------------------------
	localparam int DW = $clog2(wdtr_pkg::TICK_DIV);
	localparam int UW = $clog2(wdtr_pkg::UNLOCK_CYCLES + 1);
	localparam int RW = $clog2(wdtr_pkg::RESET_PULSE + 1);

	logic          wr_pend_q;
	logic          wr_ok_q;
	logic          rd_hit;
	logic          addr_hit;
	logic          wr_now;
	logic [7:0]    wd;
	logic          unlock_q;
	logic          enable_q;
	logic [2:0]    sel_q;
	logic [UW-1:0] ucnt_q;
	logic [DW-1:0] div_q;
	logic          tick_q;
	logic          kick_q;
	logic [RW-1:0] rst_cnt_q;
	logic          rst_q;
	logic [7:0]    ctrl_view;

	wdtr_tick_if tk ();

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	assign addr_hit  = (haddr == wdtr_pkg::CTRL_ADDR);
	assign rd_hit    = hsel && hready && htrans[1] && !hwrite;
	assign wr_now    = wr_pend_q && wr_ok_q;
	assign wd        = hwdata[7:0];
	// Reserved bits stay zero on read
	assign ctrl_view = {3'h0, unlock_q, enable_q, sel_q}; // [RULE9]

	// Address phase capture; zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_ok_q   <= 1'b0;
			hrdata    <= 32'h0000_0000;
		end else begin
			wr_pend_q <= hsel && hready && htrans[1] && hwrite;
			wr_ok_q   <= addr_hit;
			if (rd_hit) begin
				hrdata <= addr_hit ? {24'h0, ctrl_view} : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Clearing enable needs the unlock bit already standing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_q <= wdtr_pkg::CTRL_RESET[wdtr_pkg::ENABLE_BIT];
			sel_q    <= wdtr_pkg::CTRL_RESET[wdtr_pkg::SEL_MSB:0];
		end else if (wr_now) begin
			sel_q <= wd[wdtr_pkg::SEL_MSB:0];
			if (wd[wdtr_pkg::ENABLE_BIT] || unlock_q) begin
				enable_q <= wd[wdtr_pkg::ENABLE_BIT]; // [RULE4]
			end
		end
	end

	// Unlock window counted in hclk cycles from the setting write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unlock_q <= 1'b0;
			ucnt_q   <= '0;
		end else if (wr_now && wd[wdtr_pkg::UNLOCK_BIT]
				&& wd[wdtr_pkg::ENABLE_BIT]) begin
			unlock_q <= 1'b1; // [RULE12]
			ucnt_q   <= UW'(wdtr_pkg::UNLOCK_CYCLES);
		end else if (ucnt_q > UW'(1)) begin
			ucnt_q <= ucnt_q - UW'(1);
		end else begin
			unlock_q <= 1'b0; // [RULE5]
			ucnt_q   <= '0;
		end
	end

	// ------------------------------------------------------------
	// Tick divider and kick register
	// ------------------------------------------------------------
	// One 1 MHz enable pulse every TICK_DIV hclk cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q  <= '0;
			tick_q <= 1'b0;
			kick_q <= 1'b0;
		end else begin
			kick_q <= kick_instruction;
			tick_q <= (div_q == DW'(wdtr_pkg::TICK_DIV - 1)); // [RULE1]
			if (div_q == DW'(wdtr_pkg::TICK_DIV - 1)) begin
				div_q <= '0;
			end else begin
				div_q <= div_q + DW'(1);
			end
		end
	end

	assign tk.tick = tick_q;
	assign tk.kick = kick_q;
	assign tk.run  = enable_q; // [RULE6]
	assign tk.sel  = sel_q;

	wdtr_counter #(
		.BASE (BASE)
	) u_cnt (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tk      (tk)
	);

	// ------------------------------------------------------------
	// Reset request
	// ------------------------------------------------------------
	// Stretched so the reset controller cannot miss it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_cnt_q <= '0;
			rst_q     <= 1'b0;
		end else if (tk.expired) begin
			rst_cnt_q <= RW'(wdtr_pkg::RESET_PULSE); // [RULE3]
			rst_q     <= 1'b1;
		end else if (rst_cnt_q > RW'(1)) begin
			rst_cnt_q <= rst_cnt_q - RW'(1);
		end else begin
			rst_cnt_q <= '0;
			rst_q     <= 1'b0;
		end
	end

	assign device_reset_req = rst_q;
endmodule : wdtr_top
`default_nettype wire

// ===== sim/wdtr_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module wdtr_checker #(
	parameter int BASE = wdtr_pkg::BASE_TICKS
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        kick_instruction,
	input wire logic        device_reset_req
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [31:0] since_q;
	logic        rd_other;
	// Unmapped read in its address phase
	assign rd_other = hsel && hready && htrans[1] && !hwrite
		&& haddr != wdtr_pkg::CTRL_ADDR;
	// Cycles since the last kick; wide so it never wraps in a run
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			since_q <= 32'h0;
		else if (kick_instruction)
			since_q <= 32'h0;
		else
			since_q <= since_q + 32'h1;
	ready_high_a: assert property (hreadyout)
		else $error("hreadyout low");
	okay_resp_a: assert property (!hresp)
		else $error("hresp not okay");
	resv_zero_a: assert property (hrdata[31:5] == 27'h0)
		else $error("reserved read bits set");
	unmapped_zero_a: assert property (rd_other |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	pulse_width_a: assert property ($rose(device_reset_req) |->
		device_reset_req[*4] ##1 !device_reset_req)
		else $error("reset pulse width wrong");
	pulse_gap_a: assert property ($fell(device_reset_req) |->
		(!device_reset_req)[*8])
		else $error("reset pulses too close");
	// An expiry already launched before the kick registers may still show
	kick_stops_a: assert property (kick_instruction |->
		##3 !$rose(device_reset_req))
		else $error("reset after kick");
	min_period_a: assert property ($rose(device_reset_req) |->
		since_q > wdtr_pkg::TICK_DIV * (BASE - 1))
		else $error("period too short");
	cover property ($rose(device_reset_req));
	cover property (kick_instruction);
	cover property (rd_other);
endmodule // wdtr_checker
bind wdtr_top wdtr_checker #(.BASE(BASE)) chk (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
	.kick_instruction, .device_reset_req);
`default_nettype wire

// ===== sim/wdtr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Watchdog bench
// ----------------------------------------
module wdtr_top_tb;
	localparam int BASE = 2;
	localparam logic [31:0] A = wdtr_pkg::CTRL_ADDR;
	logic        hclk, hresetn, hsel, hwrite, kick, hrdy, hresp, rq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  rd;
	logic [7:0]  rows [4][2] = '{'{8'hE7, 8'h07}, '{8'h0D, 8'h0D},
		'{8'h02, 8'h0A}, '{8'hF6, 8'h0E}};
	int          mismatches, n_checks, c, n;
	wdtr_top #(.BASE(BASE)) uut (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hready(hrdy), .hwdata, .hrdata,
		.hreadyout(hrdy), .hresp, .kick_instruction(kick),
		.device_reset_req(rq));
	// Free-running clock
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Single word transfer; waits for ready in both phases
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [7:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hrdy !== 1'b1);
		rd = hrdata[7:0];
	endtask
	task automatic kick_once;
		@(posedge hclk);
		kick <= 1'b1;
		@(posedge hclk);
		kick <= 1'b0;
	endtask
	// Unlock and clear enable inside the window
	task automatic off;
		kick_once;
		bus(1'b1, A, 8'h18);
		bus(1'b1, A, 8'h00);
	endtask
	task automatic watch(input int k);
		repeat (k) begin
			@(posedge hclk);
			if (rq !== 1'b0) c++;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard, well past the expected run length
	initial begin
		#200000;
		mismatches++;
		complete_run;
	end
	initial begin
		{hresetn, hwrite, kick, htrans, haddr, hwdata} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			bus(1'b1, A, rows[i][0]);
			bus(1'b0, A, 8'h00);
			chk(rd, rows[i][1]);
		end
		bus(1'b1, 32'h80, 8'hFF);
		bus(1'b0, 32'h80, 8'h00);
		chk(rd, 8'h00);
		bus(1'b0, A, 8'h00);
		chk(rd, 8'h0E);
		$display("rows done");
		off;
		bus(1'b0, A, 8'h00);
		chk(rd, 8'h00);
		kick_once;
		bus(1'b1, A, 8'h18);
		repeat (6) @(posedge hclk);
		bus(1'b0, A, 8'h00);
		chk(rd, 8'h08);
		bus(1'b1, A, 8'h00);
		bus(1'b0, A, 8'h00);
		chk(rd, 8'h08);
		off;
		$display("unlock done");
		// Timeout length for the three shortest selects
		for (int s = 0; s < 3; s++) begin
			n = BASE << s;
			bus(1'b1, A, 8'h08 | 8'(s));
			kick_once;
			c = 0;
			while (rq !== 1'b1 && c < 9000) begin
				@(posedge hclk);
				c++;
			end
			chk(8'(c >= 250 * (n - 1) && c <= 250 * n + 8), 8'h01);
			repeat (6) @(posedge hclk);
			off;
		end
		$display("expiry done");
		bus(1'b1, A, 8'h08);
		c = 0;
		repeat (10) begin
			watch(200);
			kick_once;
		end
		chk(8'(c), 8'h00);
		off;
		c = 0;
		watch(1500);
		chk(8'(c), 8'h00);
		$display("kick and disable done");
		bus(1'b1, A, 8'h0D);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, A, 8'h00);
		chk(rd, wdtr_pkg::CTRL_RESET);
		$display("reset done");
		complete_run;
	end
endmodule // wdtr_top_tb
`default_nettype wire
